// [bench/iop_pad_model.sv]
// Pad model for the input-only and bidirectional pins, standing outside the port block
module iop_pad_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pull_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] in_pull,
   input wire logic [7:0] in_val,
   input wire logic [7:0] in_drv,
   output logic [7:0] pin_lvl,
   output logic [7:0] in_lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   // Floating lines read 1 when pulled up, else the inverse of the last external value, never a lucky guess
   always_comb begin
      pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
         | (~pin_oe & ~ext_drv & (pull_en | ~ext_val));
      in_lvl = (in_drv & in_val) | (~in_drv & (in_pull | ~in_val));
   end
endmodule // iop_pad_model

// [bench/iop_ports_checker.sv]
// Assertion checker for the port block, bound to its top module
module iop_ports_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iop_pkg::ADDR_W-1:0] paddr,
   input wire logic [iop_pkg::DATA_W-1:0] pwdata,
   input wire logic [iop_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [iop_pkg::PORT_W-1:0] input_port_pullup_en,
   input wire logic [iop_pkg::PORT_W-1:0] bidir_pin_out,
   input wire logic [iop_pkg::PORT_W-1:0] bidir_pin_oe,
   input wire logic [iop_pkg::PORT_W-1:0] bidir_pullup_en,
   input wire logic serial1_data_out,
   input wire logic serial0_clock_out,
   input wire logic serial0_clock_oe,
   input wire logic serial0_data_out,
   input wire logic [3:0] timer_outputs_0_to_3
);
   timeunit 1ns;
   timeprecision 1ns;
   import iop_pkg::*;
   logic [7:0] dir_s, func_s, pu_s, od_s, lat_s, drv, val;
   logic [7:0] next_oe, next_out, next_pu, next_in_pu;
   wire wr_ok = psel && penable && pready && pwrite;
   // Shadow copies of the registers, written on the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_s <= DIR_RESET;
         func_s <= FUNC_RESET;
         pu_s <= PULLUP_RESET;
         od_s <= OD_RESET;
         lat_s <= LATCH_RESET;
      end else if (wr_ok) begin
         case (paddr)
            OFF_BIDIR_DATA: lat_s <= pwdata[7:0];
            OFF_BIDIR_DIR: dir_s <= pwdata[7:0];
            OFF_BIDIR_FUNC: func_s <= pwdata[7:0];
            OFF_PULLUP_OPT: pu_s <= pwdata[7:0] & PULLUP_OPT_MASK;
            OFF_OPEN_DRAIN: od_s <= pwdata[7:0] & OD_CAPABLE_MASK;
            default: ;
         endcase
      end
   end
   // Expected pad controls; pads lag these by one edge
   always_comb begin
      drv = (func_s & {5'h1F, serial0_clock_oe, 2'b10}) | (~func_s & ~dir_s);
      val = (func_s & {timer_outputs_0_to_3, serial0_data_out, serial0_clock_out,
         serial1_data_out, 1'b0}) | (~func_s & lat_s);
      next_oe = drv & ~(od_s & val);
      next_out = val & ~od_s;
      next_pu = {8{pu_s[PU_BIDIR_GROUP_BIT]}} & dir_s;
      next_in_pu = {8{pu_s[PU_INPUT_GROUP_BIT]}} & INPUT_PULLUP_MASK;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_oe_match: assert property (bidir_pin_oe == $past(next_oe))
      else $error("pad enable differs from mode and direction");
   a_out_match: assert property ((bidir_pin_out & bidir_pin_oe) ==
      ($past(next_out) & $past(next_oe))) else $error("pad value differs");
   a_bidir_pull: assert property (bidir_pullup_en == $past(next_pu))
      else $error("bidir pull-up gating wrong");
   a_input_pull: assert property (input_port_pullup_en == $past(next_in_pu))
      else $error("input port pull-up wrong");
   a_reset_hiz: assert property ($rose(presetn) |-> bidir_pin_oe == 8'h00)
      else $error("pad driven right after reset");
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_ready_once: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (psel && !penable && paddr > OFF_BIDIR_PINS
      |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
endmodule // iop_ports_checker

bind iop_ports iop_ports_checker u_iop_ports_checker (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_port_pullup_en,
   .bidir_pin_out, .bidir_pin_oe, .bidir_pullup_en, .serial1_data_out,
   .serial0_clock_out, .serial0_clock_oe, .serial0_data_out, .timer_outputs_0_to_3);

// [bench/tb_top.sv]
// Self-checking bench for the input-only and bidirectional port block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import iop_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, input_port_pin, input_port_level, input_port_pullup_en;
   logic [7:0] bidir_pin_in, bidir_pin_out, bidir_pin_oe, bidir_pullup_en;
   logic [7:0] ext_val, ext_drv, in_val, in_drv;
   logic [31:0] pwdata, prdata, rd;
   logic serial1_data_in, serial1_data_out, serial0_clock_in, serial0_clock_out;
   logic serial0_clock_oe, serial0_data_out;
   logic [3:0] timer_outputs_0_to_3;
   int n_errors, tests_run, cycles;

   iop_ports u_iop_ports (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .input_port_pin, .input_port_level,
      .input_port_pullup_en, .bidir_pin_in, .bidir_pin_out, .bidir_pin_oe,
      .bidir_pullup_en, .serial1_data_in, .serial1_data_out, .serial0_clock_in,
      .serial0_clock_out, .serial0_clock_oe, .serial0_data_out, .timer_outputs_0_to_3);
   iop_pad_model u_iop_pad_model (.pin_out(bidir_pin_out), .pin_oe(bidir_pin_oe),
      .pull_en(bidir_pullup_en), .ext_val, .ext_drv, .in_pull(input_port_pullup_en),
      .in_val, .in_drv, .pin_lvl(bidir_pin_in), .in_lvl(input_port_pin));

   // ************************************************************
   // Bus and compare tasks
   // ************************************************************
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as the slave asks; only the hang guard ends it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      check("prdata", e, rd[7:0]);
      check("pslverr", {7'h0, ee}, {7'h0, err});
   endtask
   // Covers the two sync flops plus the pad register
   task automatic settle;
      repeat (5) @(posedge pclk);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      rc(OFF_BIDIR_DIR, 8'hFF, 1'b0);
      rc(OFF_BIDIR_FUNC, 8'h00, 1'b0);
      rc(OFF_PULLUP_OPT, 8'h00, 1'b0);
      check("pin_oe", 8'h00, bidir_pin_oe);
      $display("test reset done");
   endtask
   task automatic t_inport;
      in_val <= 8'hA5;
      settle;
      rc(OFF_INPUT_PORT, 8'hA5, 1'b0);
      check("in_level", 8'hA5, input_port_level);
      wr(OFF_INPUT_PORT, 8'h5A);
      rc(OFF_INPUT_PORT, 8'hA5, 1'b0);
      wr(OFF_PULLUP_OPT, 8'h04);
      in_drv <= 8'h00;
      settle;
      check("in_pullup", 8'hFC, input_port_pullup_en);
      rc(OFF_INPUT_PORT, 8'hFE, 1'b0);
      wr(OFF_PULLUP_OPT, 8'h00);
      in_drv <= 8'hFF;
      $display("test input port done");
   endtask
   task automatic t_latch;
      ext_val <= 8'hC3;
      wr(OFF_BIDIR_DATA, 8'h3C);
      settle;
      check("pin_oe", 8'h00, bidir_pin_oe);
      rc(OFF_BIDIR_DATA, 8'hC3, 1'b0);
      ext_drv <= 8'hF0;
      wr(OFF_BIDIR_DIR, 8'hF0);
      settle;
      check("pin_oe", 8'h0F, bidir_pin_oe);
      rc(OFF_BIDIR_DATA, 8'hCC, 1'b0);
      wr(OFF_BIDIR_DATA, 8'h5A);
      settle;
      rc(OFF_BIDIR_DATA, 8'hCA, 1'b0);
      ext_drv <= 8'h00;
      wr(OFF_BIDIR_DIR, 8'h00);
      settle;
      check("pin_out", 8'h5A, bidir_pin_out);
      $display("test latch done");
   endtask
   task automatic t_periph;
      serial1_data_out <= 1'b1;
      serial0_clock_oe <= 1'b1;
      serial0_data_out <= 1'b1;
      timer_outputs_0_to_3 <= 4'hA;
      wr(OFF_BIDIR_FUNC, 8'hFF);
      settle;
      check("pin_oe", 8'hFE, bidir_pin_oe);
      check("pin_out", 8'hAA, bidir_pin_out & bidir_pin_oe);
      rc(OFF_BIDIR_DATA, 8'hAA, 1'b0);
      ext_drv <= 8'h01;
      wr(OFF_BIDIR_DIR, 8'hFF);
      settle;
      rc(OFF_BIDIR_DATA, 8'hAB, 1'b0);
      rc(OFF_BIDIR_PINS, 8'hAB, 1'b0);
      check("serial1_in", 8'h01, {7'h0, serial1_data_in});
      serial0_clock_oe <= 1'b0;
      wr(OFF_PULLUP_OPT, 8'h08);
      settle;
      check("pin_oe", 8'hFA, bidir_pin_oe);
      check("pullup", 8'hFF, bidir_pullup_en);
      check("serial0_clk_in", 8'h01, {7'h0, serial0_clock_in});
      wr(OFF_BIDIR_FUNC, 8'h00);
      wr(OFF_BIDIR_DIR, 8'h0F);
      settle;
      check("pullup", 8'h0F, bidir_pullup_en);
      wr(OFF_PULLUP_OPT, 8'h00);
      $display("test peripheral done");
   endtask
   task automatic t_od;
      ext_drv <= 8'h00;
      wr(OFF_BIDIR_DIR, 8'h00);
      wr(OFF_OPEN_DRAIN, 8'hFF);
      rc(OFF_OPEN_DRAIN, 8'h0C, 1'b0);
      wr(OFF_BIDIR_DATA, 8'h04);
      settle;
      check("pin_oe", 8'hFB, bidir_pin_oe);
      check("pin_out", 8'h00, bidir_pin_out & 8'h0C);
      rc(OFF_BIDIR_DATA, 8'h04, 1'b0);
      wr(OFF_OPEN_DRAIN, 8'h00);
      rc(8'h1C, 8'h00, 1'b1);
      apb(1'b1, 8'h20, 32'hFF);
      check("pslverr", 8'h01, {7'h0, err});
      $display("test open drain done");
   endtask

   // Free-running clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         finish_test;
      end
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence, with a second reset in mid-run
   initial begin
      {presetn, psel, penable, pwrite, serial1_data_out, serial0_clock_out} = '0;
      {serial0_clock_oe, serial0_data_out, timer_outputs_0_to_3} = '0;
      {paddr, pwdata, ext_val, in_val} = '0;
      ext_drv = 8'hFF;
      in_drv = 8'hFF;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_inport;
      t_latch;
      t_periph;
      t_od;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      finish_test;
   end
endmodule // tb_top

// [hw/iop_pin_cell.sv]
// One bidirectional pin: drive, open-drain and pull-up control
module iop_pin_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic latch_val,
   input wire logic dir_input,
   input wire logic func_sel,
   input wire logic periph_val,
   input wire logic periph_drive,
   input wire logic od_en,
   input wire logic pull_group_en,
   output logic pad_out,
   output logic pad_oe,
   output logic pull_en
);
   import iop_pkg::*;

   logic drive;
   logic value;

   // Peripheral owns the pin in control mode, whatever the direction bit
   always_comb begin
      drive = func_sel ? periph_drive : ~dir_input;
      value = func_sel ? periph_val : latch_val;
   end

   // Registered pad controls; reset leaves the driver off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pull_en <= 1'b0;
      end else begin
         // Open drain only pulls low, a high leaves the pad floating
         pad_out <= od_en ? 1'b0 : value;
         pad_oe <= od_en ? (drive & ~value) : drive;
         // Gated by direction alone, so control-mode outputs get it too
         pull_en <= pull_group_en & dir_input;
      end
   end

endmodule // iop_pin_cell

// [hw/iop_pkg.sv]
// Constants shared by the input-only and bidirectional port block
package iop_pkg;

   // ***********************************************************************
   // Bus geometry
   // ***********************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;

   // ***********************************************************************
   // Register byte offsets
   // ***********************************************************************
   localparam logic [7:0] OFF_INPUT_PORT = 8'h00;
   localparam logic [7:0] OFF_BIDIR_DATA = 8'h04;
   localparam logic [7:0] OFF_BIDIR_DIR = 8'h08;
   localparam logic [7:0] OFF_BIDIR_FUNC = 8'h0C;
   localparam logic [7:0] OFF_PULLUP_OPT = 8'h10;
   localparam logic [7:0] OFF_OPEN_DRAIN = 8'h14;
   localparam logic [7:0] OFF_BIDIR_PINS = 8'h18;

   // ***********************************************************************
   // Reset values
   // ***********************************************************************
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] FUNC_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] PULLUP_RESET = 8'h00;
   localparam logic [7:0] OD_RESET = 8'h00;

   // ***********************************************************************
   // Field positions and masks
   // ***********************************************************************
   localparam int PU_INPUT_GROUP_BIT = 2;
   localparam int PU_BIDIR_GROUP_BIT = 3;
   localparam logic [7:0] PULLUP_OPT_MASK = 8'h0C;
   localparam logic [7:0] INPUT_PULLUP_MASK = 8'hFC;
   localparam logic [7:0] OD_CAPABLE_MASK = 8'h0C;

   // Control-mode signal position on the bidirectional port
   localparam int SIG_SERIAL1_IN_BIT = 0;
   localparam int SIG_SERIAL1_OUT_BIT = 1;
   localparam int SIG_SERIAL0_CLK_BIT = 2;
   localparam int SIG_SERIAL0_OUT_BIT = 3;
   localparam int SIG_TIMER_LSB = 4;

endpackage : iop_pkg

// [hw/iop_ports.sv]
// Input-only port and bidirectional muxed port with an APB register slave
//
// Contract
// - Input-only port has no direction register
// - Input port read always returns pin levels
// - One group bit enables upper six pull-ups
// - Two lowest input pins never pulled up
// - Eight bidir pins, own latch and direction
// - Bidir bits two, three offer open drain
// - Per-bit select: port or peripheral function
// - Fixed peripheral signal for each bidir bit
// - Reset makes all bidir pins high impedance inputs
// - Bidir pin levels readable at all times
// - Output bit drives latch, reads latch
// - Writes update latches of input bits too
// - Input bit reads pin, never its latch
// - Control mode serves peripheral regardless of direction
// - Peripheral output read: pin or internal signal
// - Peripheral input read only with direction one
// - Bidir pull-up needs group enable and input
// - Pull-up also reaches control-mode input-direction pins
//
// Register map, one byte register per 32-bit word
// 0x00 input port pin levels, read only
// 0x04 bidir data: writes load every latch, reads per bit
// 0x08 direction, 1 = input, all inputs after reset
// 0x0C function select, 1 = peripheral owns the pin
// 0x10 pull-up option: bit 2 input group, bit 3 bidir group
// 0x14 open drain, bits 2 and 3 only
// 0x18 bidir raw pin levels, read only
// Other offsets answer with pslverr and zero data
//
// Zero wait states; pad outputs follow a write by one edge,
// pin levels reach a read through two synchroniser flops.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module iop_ports (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iop_pkg::ADDR_W-1:0] paddr,
   input wire logic [iop_pkg::DATA_W-1:0] pwdata,
   output logic [iop_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Input-only port pins and their consumers
   input wire logic [iop_pkg::PORT_W-1:0] input_port_pin,
   output logic [iop_pkg::PORT_W-1:0] input_port_level,
   output logic [iop_pkg::PORT_W-1:0] input_port_pullup_en,
   // Bidirectional port pins
   input wire logic [iop_pkg::PORT_W-1:0] bidir_pin_in,
   output logic [iop_pkg::PORT_W-1:0] bidir_pin_out,
   output logic [iop_pkg::PORT_W-1:0] bidir_pin_oe,
   output logic [iop_pkg::PORT_W-1:0] bidir_pullup_en,
   // Peripheral side of the bidirectional port
   output logic serial1_data_in,
   input wire logic serial1_data_out,
   output logic serial0_clock_in,
   input wire logic serial0_clock_out,
   input wire logic serial0_clock_oe,
   input wire logic serial0_data_out,
   input wire logic [3:0] timer_outputs_0_to_3
);
   import iop_pkg::*;

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   logic [PORT_W-1:0] input_sync;
   logic [PORT_W-1:0] bidir_sync;
   // Software-visible control state, all in the pclk domain
   logic [PORT_W-1:0] bidir_port_latch;
   logic [PORT_W-1:0] bidir_port_direction_reg;
   logic [PORT_W-1:0] bidir_port_function_select_reg;
   logic [PORT_W-1:0] pullup_option_low_reg;
   logic [PORT_W-1:0] open_drain_reg;
   // Per-bit peripheral value and drive request
   logic [PORT_W-1:0] periph_val;
   logic [PORT_W-1:0] periph_drive;
   logic [PORT_W-1:0] bidir_read;
   // Bus decode
   logic [DATA_W-1:0] next_prdata;
   logic next_pslverr;
   logic setup_phase;
   logic access_done;
   logic wr_en;
   logic input_port_pullup_group_enable;
   logic bidir_port_pullup_group_enable;

   // ***********************************************************************
   // Pin synchronisers
   // ***********************************************************************

   // Both ports come from pads, so two flops before any use
   iop_sync #(
      .WIDTH(PORT_W)
   ) u_input_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(input_port_pin),
      .sync_out(input_sync)
   );

   iop_sync #(
      .WIDTH(PORT_W)
   ) u_bidir_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(bidir_pin_in),
      .sync_out(bidir_sync)
   );

   // ***********************************************************************
   // APB phase decode
   // ***********************************************************************

   // Zero-wait slave: pready is raised in setup so the access phase ends at once
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;
   // An unmapped write is dropped since pslverr gates the strobe
   assign wr_en = access_done & pwrite & ~pslverr;

   // Group enables taken from the pull-up option register
   assign input_port_pullup_group_enable = pullup_option_low_reg[PU_INPUT_GROUP_BIT];
   assign bidir_port_pullup_group_enable = pullup_option_low_reg[PU_BIDIR_GROUP_BIT];

   // ***********************************************************************
   // Peripheral signal routing
   // ***********************************************************************

   // Fixed assignment of peripheral signals to bidir bits
   always_comb begin
      periph_val = '0;
      periph_drive = '0;
      // Serial-1 / async receive is input only, never driven
      periph_val[SIG_SERIAL1_IN_BIT] = 1'b0;
      periph_drive[SIG_SERIAL1_IN_BIT] = 1'b0;
      periph_val[SIG_SERIAL1_OUT_BIT] = serial1_data_out;
      periph_drive[SIG_SERIAL1_OUT_BIT] = 1'b1;
      // Serial-0 clock turns round as the serial unit asks
      periph_val[SIG_SERIAL0_CLK_BIT] = serial0_clock_out;
      periph_drive[SIG_SERIAL0_CLK_BIT] = serial0_clock_oe;
      periph_val[SIG_SERIAL0_OUT_BIT] = serial0_data_out;
      periph_drive[SIG_SERIAL0_OUT_BIT] = 1'b1;
      periph_val[SIG_TIMER_LSB +: 4] = timer_outputs_0_to_3;
      periph_drive[SIG_TIMER_LSB +: 4] = 4'hF;
   end

   // An extra flop costs a cycle but keeps these outputs registered
   // Peripheral inputs see the pin in every mode; the unit decides use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial1_data_in <= 1'b0;
         serial0_clock_in <= 1'b0;
      end else begin
         serial1_data_in <= bidir_sync[SIG_SERIAL1_IN_BIT];
         serial0_clock_in <= bidir_sync[SIG_SERIAL0_CLK_BIT];
      end
   end

   // ***********************************************************************
   // Input-only port
   // ***********************************************************************

   // Levels go to every alternate consumer; no direction register exists
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_port_level <= '0;
      end else begin
         input_port_level <= input_sync;
      end
   end

   // One group bit drives six pull-ups; the lowest two have none
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_port_pullup_en <= '0;
      end else begin
         input_port_pullup_en <= {PORT_W{input_port_pullup_group_enable}}
                                 & INPUT_PULLUP_MASK;
      end
   end

   // ***********************************************************************
   // Bidirectional port control registers
   // ***********************************************************************

   // Output latches take every write whatever the bit's direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bidir_port_latch <= LATCH_RESET;
      end else if (wr_en && paddr == OFF_BIDIR_DATA) begin
         bidir_port_latch <= pwdata[PORT_W-1:0];
      end
   end

   // Direction: 1 is input, so reset leaves every pin released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bidir_port_direction_reg <= DIR_RESET;
      end else if (wr_en && paddr == OFF_BIDIR_DIR) begin
         bidir_port_direction_reg <= pwdata[PORT_W-1:0];
      end
   end

   // Function select: 1 hands the bit to its peripheral
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bidir_port_function_select_reg <= FUNC_RESET;
      end else if (wr_en && paddr == OFF_BIDIR_FUNC) begin
         bidir_port_function_select_reg <= pwdata[PORT_W-1:0];
      end
   end

   // Pull-up option: only the two group bits of this block are kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_option_low_reg <= PULLUP_RESET;
      end else if (wr_en && paddr == OFF_PULLUP_OPT) begin
         pullup_option_low_reg <= pwdata[PORT_W-1:0] & PULLUP_OPT_MASK;
      end
   end

   // Open drain exists on two pins only; other bits cannot be set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_drain_reg <= OD_RESET;
      end else if (wr_en && paddr == OFF_OPEN_DRAIN) begin
         open_drain_reg <= pwdata[PORT_W-1:0] & OD_CAPABLE_MASK;
      end
   end

   // ***********************************************************************
   // Pin cells
   // ***********************************************************************

   // Registering in the cell keeps every pad control straight off a flop
   // One cell per bit keeps drive, open drain and pull-up together
   for (genvar n = 0; n < PORT_W; n++) begin : g_pin
      iop_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .latch_val(bidir_port_latch[n]),
         .dir_input(bidir_port_direction_reg[n]),
         .func_sel(bidir_port_function_select_reg[n]),
         .periph_val(periph_val[n]),
         .periph_drive(periph_drive[n]),
         .od_en(open_drain_reg[n]),
         .pull_group_en(bidir_port_pullup_group_enable),
         .pad_out(bidir_pin_out[n]),
         .pad_oe(bidir_pin_oe[n]),
         .pull_en(bidir_pullup_en[n])
      );
   end

   // ***********************************************************************
   // Bidirectional port read value
   // ***********************************************************************

   // Per-bit read mux; a control-mode input with direction 0 reads 0
   always_comb begin
      bidir_read = '0;
      for (int n = 0; n < PORT_W; n++) begin
         if (bidir_port_function_select_reg[n]) begin
            if (bidir_port_direction_reg[n]) begin
               bidir_read[n] = bidir_sync[n];
            end else if (periph_drive[n]) begin
               bidir_read[n] = periph_val[n];
            end else begin
               bidir_read[n] = 1'b0;
            end
         end else if (bidir_port_direction_reg[n]) begin
            bidir_read[n] = bidir_sync[n];
         end else begin
            bidir_read[n] = bidir_port_latch[n];
         end
      end
   end

   // ***********************************************************************
   // APB read data and error
   // ***********************************************************************

   // Pin reads use synchronised levels, two edges behind the pads
   // Decode in setup; unmapped offsets answer with an error and zero
   always_comb begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      case (paddr)
         OFF_INPUT_PORT: begin
            next_prdata[PORT_W-1:0] = input_sync;
         end
         OFF_BIDIR_DATA: begin
            next_prdata[PORT_W-1:0] = bidir_read;
         end
         OFF_BIDIR_DIR: begin
            next_prdata[PORT_W-1:0] = bidir_port_direction_reg;
         end
         OFF_BIDIR_FUNC: begin
            next_prdata[PORT_W-1:0] = bidir_port_function_select_reg;
         end
         OFF_PULLUP_OPT: begin
            next_prdata[PORT_W-1:0] = pullup_option_low_reg;
         end
         OFF_OPEN_DRAIN: begin
            next_prdata[PORT_W-1:0] = open_drain_reg;
         end
         OFF_BIDIR_PINS: begin
            next_prdata[PORT_W-1:0] = bidir_sync;
         end
         default: begin
            next_pslverr = 1'b1;
         end
      endcase
   end

   // Writes return zero so stale read data never leaks onto the bus
   // Response flops: loaded at the setup edge, held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= pwrite ? '0 : next_prdata;
         pslverr <= next_pslverr;
      end else if (access_done) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end

   // No wait states, so each decode must settle within one cycle
   // Ready rises with setup and drops after the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

endmodule // iop_ports

// [hw/iop_sync.sv]
// Two-flop synchroniser for a group of pin levels
module iop_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import iop_pkg::*;

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule // iop_sync
